// file: rtl/tlic_top.sv
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module tlic_top
  import tlic_pkg::*;
  (input  wire logic        clock_i,
   input  wire logic        rstn_i,
   // Avalon-MM slave.
   input  wire logic [7:0]  address_i,
   input  wire logic [3:0]  byteenable_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // Source flags from peripherals on the same clock.
   input  wire logic        supply_monitor_request_i,
   input  wire logic        watchdog_timeout_flag_i,
   input  wire logic        external0_request_i,
   input  wire logic [1:0]  converter_ready_flags_i,
   input  wire logic        timer0_overflow_flag_i,
   input  wire logic        external1_request_i,
   input  wire logic        timer1_overflow_flag_i,
   input  wire logic        spi_request_flag_i,
   input  wire logic        uart_receive_flag_i,
   input  wire logic        uart_transmit_flag_i,
   input  wire logic        timer2_overflow_flag_i,
   input  wire logic        timer2_external_flag_i,
   input  wire logic        interval_timer_request_i,
   // Core side.
   input  wire logic        irq_ack_i,
   input  wire logic        reti_i,
   output logic             irq_req_o,
   output logic             irq_high_o,
   output logic [15:0]      irq_vector_o);

  // Software-visible registers.
  logic [7:0] pri_en_r;
  logic [7:0] pri_prio_r;
  logic [7:0] sec_r;
  logic [7:0] wdog_r;

  // Bus response registers.
  logic        waitrequest_r;
  logic        waitrequest_nxt;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;

  // Request presented to the core.
  logic        irq_req_r;
  logic        irq_req_nxt;
  logic        irq_high_r;
  logic        irq_high_nxt;
  logic [15:0] irq_vector_r;
  logic [15:0] irq_vector_nxt;

  // Decode of the bus request.
  wire bus_req     = read_i | write_i;
  wire wr_accept   = write_i & ~waitrequest_r;
  wire wr_lane0    = wr_accept & byteenable_i[0];
  wire sel_pri_en  = (address_i == OFS_PRI_EN);
  wire sel_prio    = (address_i == OFS_PRI_PRIO);
  wire sel_sec     = (address_i == OFS_SEC);
  wire sel_wdog    = (address_i == OFS_WDOG);
  wire sel_status  = (address_i == OFS_STATUS);
  wire [7:0] wbyte = writedata_i[7:0];

  // Qualified enables; the global bit gates every maskable source.
  wire global_en = pri_en_r[PRI_GLOBAL_EN];
  wire [WD_TO_W-1:0] wd_timeout = wdog_r[WD_TO_LSB +: WD_TO_W];
  wire wd_mode   = wdog_r[WD_MODE_BIT];

  // Raw flags merged per source in polling order.
  logic [NUM_SRC-1:0] flag_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] prio_vec;
  logic [NUM_SRC-1:0] req_vec;

  // Source flags; combined sources raise one request each.
  assign flag_vec[SRC_PSM]  = supply_monitor_request_i;
  assign flag_vec[SRC_WDOG] = watchdog_timeout_flag_i;
  assign flag_vec[SRC_EXT0] = external0_request_i;
  assign flag_vec[SRC_CONV] = |converter_ready_flags_i;
  assign flag_vec[SRC_TMR0] = timer0_overflow_flag_i;
  assign flag_vec[SRC_EXT1] = external1_request_i;
  assign flag_vec[SRC_TMR1] = timer1_overflow_flag_i;
  assign flag_vec[SRC_SPI]  = spi_request_flag_i;
  assign flag_vec[SRC_UART] = uart_receive_flag_i | uart_transmit_flag_i;
  assign flag_vec[SRC_TMR2] = timer2_overflow_flag_i
                            | timer2_external_flag_i;
  assign flag_vec[SRC_ITMR] = interval_timer_request_i;

  // Individual enables. The watchdog has none beyond its own mode bit
  // and a nonzero timeout, since a zero timeout never expires cleanly.
  assign en_vec[SRC_PSM]  = sec_r[SEC_PSM_EN];
  assign en_vec[SRC_WDOG] = wd_mode & (wd_timeout != '0);
  assign en_vec[SRC_EXT0] = pri_en_r[PRI_EXT0];
  assign en_vec[SRC_CONV] = pri_en_r[PRI_CONV];
  assign en_vec[SRC_TMR0] = pri_en_r[PRI_TMR0];
  assign en_vec[SRC_EXT1] = pri_en_r[PRI_EXT1];
  assign en_vec[SRC_TMR1] = pri_en_r[PRI_TMR1];
  assign en_vec[SRC_SPI]  = sec_r[SEC_SPI_EN];
  assign en_vec[SRC_UART] = pri_en_r[PRI_UART];
  assign en_vec[SRC_TMR2] = pri_en_r[PRI_TMR2];
  assign en_vec[SRC_ITMR] = sec_r[SEC_ITMR_EN];

  // Level of each source, one bit each: 1 high, 0 low.
  assign prio_vec[SRC_PSM]  = sec_r[SEC_PSM_PRIO];
  assign prio_vec[SRC_WDOG] = 1'b1;
  assign prio_vec[SRC_EXT0] = pri_prio_r[PRI_EXT0];
  assign prio_vec[SRC_CONV] = pri_prio_r[PRI_CONV];
  assign prio_vec[SRC_TMR0] = pri_prio_r[PRI_TMR0];
  assign prio_vec[SRC_EXT1] = pri_prio_r[PRI_EXT1];
  assign prio_vec[SRC_TMR1] = pri_prio_r[PRI_TMR1];
  assign prio_vec[SRC_SPI]  = sec_r[SEC_SPI_PRIO];
  assign prio_vec[SRC_UART] = pri_prio_r[PRI_UART];
  assign prio_vec[SRC_TMR2] = pri_prio_r[PRI_TMR2];
  assign prio_vec[SRC_ITMR] = sec_r[SEC_ITMR_PRIO];

  // Live requests: flag, enable and global enable, except the watchdog.
  always_comb begin
    req_vec = flag_vec & en_vec & {NUM_SRC{global_en}};
    req_vec[SRC_WDOG] = flag_vec[SRC_WDOG] & en_vec[SRC_WDOG];
  end

  // One encoder per level, each polling in the fixed order.
  tlic_enc_if #(.N(NUM_SRC)) hi_if ();
  tlic_enc_if #(.N(NUM_SRC)) lo_if ();
  tlic_lvl_if                lvl_if ();

  assign hi_if.pend = req_vec & prio_vec;
  assign lo_if.pend = req_vec & ~prio_vec;

  tlic_prio_enc #(.N(NUM_SRC)) u_enc_hi (
    .port (hi_if.enc)
  );

  tlic_prio_enc #(.N(NUM_SRC)) u_enc_lo (
    .port (lo_if.enc)
  );

  tlic_level_track u_level (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .lvl     (lvl_if.trk)
  );

  // Entry happens when the core accepts the presented request.
  wire take = irq_req_r & irq_ack_i;
  assign lvl_if.take    = take;
  assign lvl_if.take_hi = irq_high_r;
  assign lvl_if.reti    = reti_i;

  // A high request may interrupt a low routine but never a high one;
  // a low request waits for both levels to be idle.
  wire grant_hi = hi_if.valid & ~lvl_if.active_hi;
  wire grant_lo = lo_if.valid & ~hi_if.valid
                & ~lvl_if.active_hi & ~lvl_if.active_lo;
  wire [SRC_IDX_W-1:0] win_idx = grant_hi ? hi_if.idx : lo_if.idx;

  // Vector table lookup by polling index.
  function automatic logic [15:0] vec_of(input logic [SRC_IDX_W-1:0] i);
    logic [15:0] v;
    v = VEC_WDOG;
    case (int'(i))
      SRC_PSM:  v = VEC_PSM;
      SRC_WDOG: v = VEC_WDOG;
      SRC_EXT0: v = VEC_EXT0;
      SRC_CONV: v = VEC_CONV;
      SRC_TMR0: v = VEC_TMR0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_TMR1: v = VEC_TMR1;
      SRC_SPI:  v = VEC_SPI;
      SRC_UART: v = VEC_UART;
      SRC_TMR2: v = VEC_TMR2;
      SRC_ITMR: v = VEC_ITMR;
      default:  v = VEC_WDOG;
    endcase
    return v;
  endfunction : vec_of

  // The request drops for one cycle after acceptance, because the level
  // tracker only shows the new routine one edge later; this keeps a
  // same-level source from being presented in that gap.
  always_comb begin
    irq_req_nxt    = (grant_hi | grant_lo) & ~take;
    irq_high_nxt   = grant_hi;
    irq_vector_nxt = irq_vector_r;
    if (grant_hi | grant_lo) begin
      irq_vector_nxt = vec_of(win_idx);
    end
  end

  // Registered request towards the core.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_req_r    <= 1'b0;
      irq_high_r   <= 1'b0;
      irq_vector_r <= 16'h0000;
    end else begin
      irq_req_r    <= irq_req_nxt;
      irq_high_r   <= irq_high_nxt;
      irq_vector_r <= irq_vector_nxt;
    end
  end

  // Read multiplexer; unmapped offsets read as zero. Reserved bit 7 of
  // the secondary register keeps its reset value.
  always_comb begin
    readdata_nxt = 32'h0000_0000;
    if (sel_pri_en) begin
      readdata_nxt[7:0] = pri_en_r;
    end else if (sel_prio) begin
      readdata_nxt[7:0] = pri_prio_r;
    end else if (sel_sec) begin
      readdata_nxt[7:0] = sec_r;
    end else if (sel_wdog) begin
      readdata_nxt[7:0] = wdog_r;
    end else if (sel_status) begin
      readdata_nxt[NUM_SRC-1:0] = req_vec;
      readdata_nxt[16]          = lvl_if.active_hi;
      readdata_nxt[17]          = lvl_if.active_lo;
      readdata_nxt[18]          = irq_req_r;
      readdata_nxt[19]          = irq_high_r;
    end
  end

  // One wait state: waitrequest falls for a single cycle per request,
  // which costs a cycle but keeps every answer registered.
  assign waitrequest_nxt = ~(bus_req & waitrequest_r);

  // Bus response registers.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h0000_0000;
    end else begin
      waitrequest_r <= waitrequest_nxt;
      if (read_i & waitrequest_r) begin
        readdata_r <= readdata_nxt;
      end
    end
  end

  // Register writes on the low byte lane. Bit 3 of the secondary
  // register is stored as written; software is expected to keep it 0.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pri_en_r   <= RST_PRI_EN;
      pri_prio_r <= RST_PRI_PRIO;
      sec_r      <= RST_SEC;
      wdog_r     <= RST_WDOG;
    end else if (wr_lane0) begin
      if (sel_pri_en) begin
        pri_en_r <= wbyte;
      end
      if (sel_prio) begin
        pri_prio_r <= wbyte;
      end
      if (sel_sec) begin
        sec_r[SEC_RSVD-1:0] <= wbyte[SEC_RSVD-1:0];
      end
      if (sel_wdog) begin
        wdog_r <= wbyte;
      end
    end
  end

  assign readdata_o    = readdata_r;
  assign waitrequest_o = waitrequest_r;
  assign irq_req_o     = irq_req_r;
  assign irq_high_o    = irq_high_r;
  assign irq_vector_o  = irq_vector_r;

endmodule : tlic_top

// file: inc/tlic_pkg.sv
package tlic_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_PRI_EN   = 8'h00;
  localparam logic [7:0] OFS_PRI_PRIO = 8'h04;
  localparam logic [7:0] OFS_SEC      = 8'h08;
  localparam logic [7:0] OFS_WDOG     = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  // Values after reset.
  localparam logic [7:0] RST_PRI_EN   = 8'h00;
  localparam logic [7:0] RST_PRI_PRIO = 8'h00;
  localparam logic [7:0] RST_SEC      = 8'hA0;
  localparam logic [7:0] RST_WDOG     = 8'h00;

  // Field positions in the secondary register.
  localparam int SEC_ITMR_PRIO = 6;
  localparam int SEC_PSM_PRIO  = 5;
  localparam int SEC_SPI_PRIO  = 4;
  localparam int SEC_MUST_ZERO = 3;
  localparam int SEC_ITMR_EN   = 2;
  localparam int SEC_PSM_EN    = 1;
  localparam int SEC_SPI_EN    = 0;
  localparam int SEC_RSVD      = 7;

  // Field positions in the primary enable register.
  localparam int PRI_GLOBAL_EN = 7;
  localparam int PRI_CONV      = 6;
  localparam int PRI_TMR2      = 5;
  localparam int PRI_UART      = 4;
  localparam int PRI_TMR1      = 3;
  localparam int PRI_EXT1      = 2;
  localparam int PRI_TMR0      = 1;
  localparam int PRI_EXT0      = 0;

  // Watchdog control register fields.
  localparam int WD_MODE_BIT = 0;
  localparam int WD_TO_LSB   = 4;
  localparam int WD_TO_W     = 4;

  // Sources in polling order, index 0 polled first.
  localparam int NUM_SRC   = 11;
  localparam int SRC_IDX_W = 4;
  localparam int SRC_PSM   = 0;
  localparam int SRC_WDOG  = 1;
  localparam int SRC_EXT0  = 2;
  localparam int SRC_CONV  = 3;
  localparam int SRC_TMR0  = 4;
  localparam int SRC_EXT1  = 5;
  localparam int SRC_TMR1  = 6;
  localparam int SRC_SPI   = 7;
  localparam int SRC_UART  = 8;
  localparam int SRC_TMR2  = 9;
  localparam int SRC_ITMR  = 10;

  // Vector addresses.
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TMR2 = 16'h002B;
  localparam logic [15:0] VEC_CONV = 16'h0033;
  localparam logic [15:0] VEC_SPI  = 16'h003B;
  localparam logic [15:0] VEC_PSM  = 16'h0043;
  localparam logic [15:0] VEC_ITMR = 16'h0053;
  localparam logic [15:0] VEC_WDOG = 16'h005B;

endpackage : tlic_pkg

// file: inc/tlic_if.sv
`timescale 1ns/100ps
// Pending vector in, winner out, for one priority level.
interface tlic_enc_if
  import tlic_pkg::*;
  #(parameter int N = NUM_SRC);
  logic [N-1:0]         pend;
  logic                 valid;
  logic [SRC_IDX_W-1:0] idx;
  modport enc  (input pend, output valid, output idx);
  modport user (output pend, input valid, input idx);
endinterface : tlic_enc_if

// Entry and return events and the in-service levels.
interface tlic_lvl_if;
  logic take;
  logic take_hi;
  logic reti;
  logic active_hi;
  logic active_lo;
  modport trk  (input take, input take_hi, input reti,
                output active_hi, output active_lo);
  modport user (output take, output take_hi, output reti,
                input active_hi, input active_lo);
endinterface : tlic_lvl_if

// file: rtl/tlic_prio_enc.sv
`timescale 1ns/100ps
module tlic_prio_enc
  import tlic_pkg::*;
  #(parameter int N = NUM_SRC)
  (tlic_enc_if.enc port);

  // Lowest index wins, so scanning downward leaves the first one polled.
  always_comb begin
    port.valid = 1'b0;
    port.idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (port.pend[i]) begin
        port.valid = 1'b1;
        port.idx   = SRC_IDX_W'(i);
      end
    end
  end

endmodule : tlic_prio_enc

// file: rtl/tlic_level_track.sv
`timescale 1ns/100ps
module tlic_level_track
  import tlic_pkg::*;
  (input  wire logic clock_i,
   input  wire logic rstn_i,
   tlic_lvl_if.trk   lvl);

  logic active_hi_r;
  logic active_lo_r;
  logic active_hi_nxt;
  logic active_lo_nxt;

  // A return closes the highest level in service; an entry in the same
  // cycle is applied after it so the new routine is never lost.
  always_comb begin
    active_hi_nxt = active_hi_r;
    active_lo_nxt = active_lo_r;
    if (lvl.reti) begin
      if (active_hi_r) begin
        active_hi_nxt = 1'b0;
      end else begin
        active_lo_nxt = 1'b0;
      end
    end
    if (lvl.take) begin
      if (lvl.take_hi) begin
        active_hi_nxt = 1'b1;
      end else begin
        active_lo_nxt = 1'b1;
      end
    end
  end

  // State of the two in-service levels.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_hi_r <= 1'b0;
      active_lo_r <= 1'b0;
    end else begin
      active_hi_r <= active_hi_nxt;
      active_lo_r <= active_lo_nxt;
    end
  end

  assign lvl.active_hi = active_hi_r;
  assign lvl.active_lo = active_lo_r;

endmodule : tlic_level_track

// file: test/tlic_checker.sv
`timescale 1ns/100ps
// Watches the top ports and shadows the enable, secondary and watchdog registers from completed writes.
module tlic_checker
  import tlic_pkg::*;
  (input wire logic        clock_i,
   input wire logic        rstn_i,
   input wire logic [7:0]  address_i,
   input wire logic [3:0]  byteenable_i,
   input wire logic        write_i,
   input wire logic [31:0] writedata_i,
   input wire logic        waitrequest_o,
   input wire logic        supply_monitor_request_i,
   input wire logic        watchdog_timeout_flag_i,
   input wire logic        spi_request_flag_i,
   input wire logic        interval_timer_request_i,
   input wire logic        irq_ack_i,
   input wire logic        reti_i,
   input wire logic        irq_req_o,
   input wire logic        irq_high_o,
   input wire logic [15:0] irq_vector_o);
  logic [7:0] ie_r;
  logic [7:0] sec_r;
  logic [7:0] wd_r;
  logic       hi_r;
  logic       lo_r;
  wire        wr_done = write_i && !waitrequest_o && byteenable_i[0];
  wire        hi_held = hi_r && !reti_i;
  wire        lo_held = lo_r && !(reti_i && !hi_r);
  // Shadows change at the same edge as the real registers.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ie_r  <= RST_PRI_EN;
      sec_r <= RST_SEC;
      wd_r  <= RST_WDOG;
    end else if (wr_done) begin
      if (address_i == OFS_PRI_EN) ie_r <= writedata_i[7:0];
      if (address_i == OFS_SEC) sec_r <= writedata_i[7:0];
      if (address_i == OFS_WDOG) wd_r <= writedata_i[7:0];
    end
  end
  // Levels in service; a return closes the higher one first.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else begin
      if (reti_i && hi_r) hi_r <= 1'b0;
      else if (reti_i) lo_r <= 1'b0;
      if (irq_req_o && irq_ack_i && irq_high_o) hi_r <= 1'b1;
      if (irq_req_o && irq_ack_i && !irq_high_o) lo_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    irq_req_o && irq_ack_i;
  endsequence
  sequence s_vec(logic [15:0] v);
    irq_req_o && irq_vector_o == v;
  endsequence
  property p_ack_drop;
    s_take |=> !irq_req_o;
  endproperty
  property p_itmr_en;
    s_vec(VEC_ITMR) |->
      $past(interval_timer_request_i && sec_r[SEC_ITMR_EN]);
  endproperty
  property p_psm_en;
    s_vec(VEC_PSM) |-> $past(supply_monitor_request_i && sec_r[SEC_PSM_EN]);
  endproperty
  property p_spi_en;
    s_vec(VEC_SPI) |-> $past(spi_request_flag_i && sec_r[SEC_SPI_EN]);
  endproperty
  property p_itmr_lvl;
    s_vec(VEC_ITMR) |-> irq_high_o == $past(sec_r[SEC_ITMR_PRIO]);
  endproperty
  property p_wdog;
    s_vec(VEC_WDOG) |-> irq_high_o && $past(watchdog_timeout_flag_i &&
      wd_r[WD_MODE_BIT] && wd_r[7:4] != 4'h0);
  endproperty
  property p_global;
    irq_req_o && irq_vector_o != VEC_WDOG |-> $past(ie_r[PRI_GLOBAL_EN]);
  endproperty
  property p_same_lvl;
    irq_req_o && irq_high_o |-> !$past(hi_held);
  endproperty
  property p_low_wait;
    irq_req_o && !irq_high_o |-> !$past(hi_held) && !$past(lo_held);
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request stayed up after acknowledge");
  a_itmr_en: assert property (p_itmr_en)
    else $error("interval timer request while disabled");
  a_psm_en: assert property (p_psm_en)
    else $error("supply monitor request while disabled");
  a_spi_en: assert property (p_spi_en)
    else $error("spi request while disabled");
  a_itmr_lvl: assert property (p_itmr_lvl)
    else $error("interval timer level wrong");
  a_wdog: assert property (p_wdog)
    else $error("watchdog request wrong");
  a_global: assert property (p_global)
    else $error("maskable request with global enable off");
  a_same_lvl: assert property (p_same_lvl)
    else $error("high request during high routine");
  a_low_wait: assert property (p_low_wait)
    else $error("low request during a routine");
endmodule : tlic_checker

bind tlic_top tlic_checker i_tlic_checker (.clock_i(clock_i),
  .rstn_i(rstn_i), .address_i(address_i), .byteenable_i(byteenable_i),
  .write_i(write_i), .writedata_i(writedata_i),
  .waitrequest_o(waitrequest_o),
  .supply_monitor_request_i(supply_monitor_request_i),
  .watchdog_timeout_flag_i(watchdog_timeout_flag_i),
  .spi_request_flag_i(spi_request_flag_i),
  .interval_timer_request_i(interval_timer_request_i),
  .irq_ack_i(irq_ack_i), .reti_i(reti_i), .irq_req_o(irq_req_o),
  .irq_high_o(irq_high_o), .irq_vector_o(irq_vector_o));

// file: test/tlic_core_model.sv
`timescale 1ns/100ps
// Core stand-in: acks presented requests, loads vectors, returns on demand.
module tlic_core_model
  import tlic_pkg::*;
  (input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic        irq_req_i,
   input  wire logic [15:0] irq_vector_i,
   input  wire logic        take_en_i,
   input  wire logic        slow_i,
   input  wire logic        ret_i,
   output logic             irq_ack_o,
   output logic             reti_o,
   output logic      [15:0] pc_o,
   output logic      [2:0]  depth_o);
  logic [15:0] stack_r [4];
  logic [1:0]  wait_r;
  // A slow core lets the request stand four cycles before it acks.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ack_o <= 1'b0;
      reti_o    <= 1'b0;
      wait_r    <= 2'h0;
      pc_o      <= 16'h0100;
      depth_o   <= 3'h0;
    end else begin
      reti_o    <= ret_i;
      wait_r    <= (irq_req_i && take_en_i) ? wait_r + 2'h1 : 2'h0;
      irq_ack_o <= irq_req_i && take_en_i && !irq_ack_o &&
                   (!slow_i || wait_r == 2'h3);
      if (irq_ack_o && irq_req_i) begin
        stack_r[depth_o[1:0]] <= pc_o;
        pc_o    <= irq_vector_i;
        depth_o <= depth_o + 3'h1;
      end else if (reti_o && depth_o != 3'h0) begin
        pc_o    <= stack_r[depth_o[1:0] - 2'h1];
        depth_o <= depth_o - 3'h1;
      end
    end
  end
endmodule : tlic_core_model

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench
  import tlic_pkg::*;
  ;
  logic clock_i, rstn_i, read_i, write_i, alt, take_en, slow, ret_cmd;
  logic [7:0] address_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i, readdata_o, stat;
  logic waitrequest_o, irq_ack_i, reti_i, irq_req_o, irq_high_o;
  logic [15:0] irq_vector_o, pc;
  logic [2:0] depth;
  logic [10:0] flg;
  int miscompares, comparisons, cycles, k;
  logic [15:0] vtab [NUM_SRC] = '{VEC_PSM, VEC_WDOG, VEC_EXT0, VEC_CONV,
    VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SPI, VEC_UART, VEC_TMR2, VEC_ITMR};
  tlic_top i_tlic_top (.clock_i(clock_i), .rstn_i(rstn_i),
    .address_i(address_i), .byteenable_i(byteenable_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .supply_monitor_request_i(flg[SRC_PSM]),
    .watchdog_timeout_flag_i(flg[SRC_WDOG]),
    .external0_request_i(flg[SRC_EXT0]),
    .converter_ready_flags_i({flg[SRC_CONV] & alt, flg[SRC_CONV] & !alt}),
    .timer0_overflow_flag_i(flg[SRC_TMR0]),
    .external1_request_i(flg[SRC_EXT1]),
    .timer1_overflow_flag_i(flg[SRC_TMR1]),
    .spi_request_flag_i(flg[SRC_SPI]),
    .uart_receive_flag_i(flg[SRC_UART] & !alt),
    .uart_transmit_flag_i(flg[SRC_UART] & alt),
    .timer2_overflow_flag_i(flg[SRC_TMR2] & !alt),
    .timer2_external_flag_i(flg[SRC_TMR2] & alt),
    .interval_timer_request_i(flg[SRC_ITMR]), .irq_ack_i(irq_ack_i),
    .reti_i(reti_i), .irq_req_o(irq_req_o), .irq_high_o(irq_high_o),
    .irq_vector_o(irq_vector_o));
  tlic_core_model i_tlic_core_model (.clock_i(clock_i), .rstn_i(rstn_i),
    .irq_req_i(irq_req_o), .irq_vector_i(irq_vector_o),
    .take_en_i(take_en), .slow_i(slow), .ret_i(ret_cmd),
    .irq_ack_o(irq_ack_i), .reti_o(reti_i), .pc_o(pc), .depth_o(depth));

  always #20 clock_i = ~clock_i;

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One Avalon transfer; the request stands until waitrequest is seen low.
  // Only the global cycle ceiling ends a wait that never finishes.
  task bus(input logic rd_n, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] q);
    @(posedge clock_i);
    address_i   <= a;
    writedata_i <= {24'h00_0000, d};
    read_i      <= rd_n;
    write_i     <= !rd_n;
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    check(q, {24'h00_0000, e});
  endtask : rd

  // Waits for a request, checks it, lets the core take it, clears the flag.
  task take(input int s, input logic hi);
    int n;
    logic [2:0] d0;
    n = 0;
    while (irq_req_o !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    check({16'h0000, irq_vector_o}, {16'h0000, vtab[s]});
    check({31'h0000_0000, irq_high_o}, {31'h0000_0000, hi});
    d0 = depth;
    take_en <= 1'b1;
    while (depth === d0 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    take_en <= 1'b0;
    flg[s]  <= 1'b0;
    check({16'h0000, pc}, {16'h0000, vtab[s]});
  endtask : take

  task ret;
    @(posedge clock_i);
    ret_cmd <= 1'b1;
    @(posedge clock_i);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : ret

  // Request latency is one cycle, so four quiet cycles prove a refusal.
  task quiet;
    repeat (4) @(posedge clock_i);
    check({31'h0000_0000, irq_req_o}, 32'h0000_0000);
  endtask : quiet

  task end_sim;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // A hang is cut short long after the tests should have finished.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    {clock_i, rstn_i, read_i, write_i, alt, take_en, slow, ret_cmd} = '0;
    {address_i, writedata_i, flg} = '0;
    byteenable_i = 4'h1;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(OFS_PRI_EN, RST_PRI_EN);
    rd(OFS_PRI_PRIO, RST_PRI_PRIO);
    rd(OFS_SEC, RST_SEC);
    rd(OFS_WDOG, RST_WDOG);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    wr(OFS_SEC, 8'h00);
    rd(OFS_SEC, 8'h80);
    byteenable_i <= 4'h0;
    wr(OFS_PRI_EN, 8'hFF);
    byteenable_i <= 4'h1;
    rd(OFS_PRI_EN, 8'h00);
    $display("test registers done");
    wr(OFS_PRI_EN, 8'hFF);
    wr(OFS_SEC, 8'h07);
    wr(OFS_WDOG, 8'hF1);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        alt    <= p[0];
        slow   <= i[0];
        flg[i] <= 1'b1;
        take(i, i == SRC_WDOG);
        ret();
      end
    end
    $display("test vectors done");
    flg <= 11'h7FF;
    for (int j = 0; j < NUM_SRC; j++) begin
      k = (j == 0) ? SRC_WDOG : (j == 1) ? SRC_PSM : j;
      take(k, k == SRC_WDOG);
      ret();
    end
    $display("test polling done");
    for (int b = 4; b < 7; b++) begin
      k = (b == 6) ? SRC_ITMR : (b == 5) ? SRC_PSM : SRC_SPI;
      wr(OFS_SEC, 8'h07 | (8'h01 << b));
      rd(OFS_SEC, 8'h87 | (8'h01 << b));
      flg[k] <= 1'b1;
      flg[SRC_EXT0] <= 1'b1;
      take(k, 1'b1);
      ret();
      take(SRC_EXT0, 1'b0);
      ret();
    end
    $display("test levels done");
    wr(OFS_SEC, 8'h07);
    wr(OFS_PRI_PRIO, 8'h01);
    flg[SRC_ITMR] <= 1'b1;
    take(SRC_ITMR, 1'b0);
    flg[SRC_SPI] <= 1'b1;
    quiet();
    bus(1'b1, OFS_STATUS, 8'h00, stat);
    check(stat, 32'h0002_0080);
    flg[SRC_EXT0] <= 1'b1;
    take(SRC_EXT0, 1'b1);
    ret();
    quiet();
    ret();
    take(SRC_SPI, 1'b0);
    ret();
    $display("test preemption done");
    wr(OFS_PRI_EN, 8'h7F);
    flg <= 11'h7FD;
    quiet();
    flg[SRC_WDOG] <= 1'b1;
    take(SRC_WDOG, 1'b1);
    ret();
    wr(OFS_WDOG, 8'h01);
    flg[SRC_WDOG] <= 1'b1;
    quiet();
    wr(OFS_PRI_EN, 8'h80);
    wr(OFS_SEC, 8'h70);
    quiet();
    flg <= 11'h004;
    wr(OFS_PRI_EN, 8'h81);
    take(SRC_EXT0, 1'b1);
    ret();
    $display("test masking done");
    end_sim();
  end
endmodule : testbench
